/* adf_ctrl.sv */
`timescale 1ns/100ps
module adf_fifo #(
	parameter int W = 16,
	parameter int D = 32
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic inVal,
	output logic inRdy,
	input wire logic [W-1:0] inData,
	output logic outVal,
	input wire logic outRdy,
	output logic [W-1:0] outData
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW:0] wp_q, rp_q;
	logic push, pop;

	// Pointers carry a wrap bit so full and empty differ
	assign inRdy = (wp_q - rp_q) != (AW+1)'(D);
	assign outVal = wp_q != rp_q;
	assign outData = mem[rp_q[AW-1:0]];
	assign push = inVal & inRdy;
	assign pop = outVal & outRdy;

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wp_q[AW-1:0]] <= inData;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wp_q <= '0;
			rp_q <= '0;
		end else begin
			wp_q <= wp_q + (AW+1)'(push);
			rp_q <= rp_q + (AW+1)'(pop);
		end
	end
endmodule

module adf_ctrl #(
	parameter int DrqMaxCyc = adf_pkg::DRQ_MAX_US * adf_pkg::CLK_MHZ
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic intrq,
	input wire logic slaveDiagOkN,
	output logic flushReq,
	input wire logic flushDone,
	output logic fmtReq,
	input wire logic fmtDone,
	output logic fmtLba,
	output logic [27:0] fmtAddr,
	output logic [8:0] fmtCount
);
	import adf_pkg::*;

	typedef enum logic [5:0] {
		S_IDLE = 6'b000001,
		S_DIAG = 6'b000010,
		S_FLUSH = 6'b000100,
		S_FMTBUF = 6'b001000,
		S_FMTMED = 6'b010000,
		S_IDENT = 6'b100000
	} adf_state_t;

	adf_state_t st_q;
	logic [7:0] feat_q, scnt_q, snum_q, cylo_q, cyhi_q, dh_q, err_q;
	logic [3:0] ctrl_q;
	logic bsy_q, drq_q, errSt_q, done_q;
	logic [8:0] genCnt_q, xfer_q;
	logic sync1_q, sync2_q;
	logic acc, isData, go, cmdWr, selected, slaveBad;
	logic pushApb, popApb, drain, fifoInVal, fifoInRdy;
	logic fifoOutVal, fifoOutRdy, genVal;
	logic [15:0] fifoInData, fifoOutData, genWord;

	// Slave's diagnostic pin crosses in through two flops
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sync1_q <= 1'b1;
			sync2_q <= 1'b1;
		end else begin
			sync1_q <= slaveDiagOkN;
			sync2_q <= sync1_q;
		end
	end
	assign slaveBad = sync2_q;

	// Bus decode; data writes stall on a full FIFO in format, reads on an empty one in identify
	assign acc = psel & penable & ~pready;
	assign isData = paddr == OFF_DATA;
	assign go = acc & (~isData | (pwrite ?
		(st_q != S_FMTBUF | fifoInRdy) :
		(st_q != S_IDENT | fifoOutVal)));
	assign cmdWr = go & pwrite & (paddr == OFF_STATCMD);
	assign selected = dh_q[DH_DRV] == ctrl_q[CT_SLAVE];
	assign pushApb = go & pwrite & isData & st_q == S_FMTBUF;
	assign popApb = go & ~pwrite & isData & st_q == S_IDENT;
	assign drain = st_q == S_FMTBUF & drq_q;

	// Identify block: only word 0 carries data [R12]
	assign genWord = (genCnt_q == 9'h000) ? IDENT_W0 : 16'h0000;
	assign genVal = st_q == S_IDENT & ~genCnt_q[8];
	assign fifoInVal = (st_q == S_IDENT) ? genVal : pushApb;
	assign fifoInData = (st_q == S_IDENT) ? genWord : pwdata[15:0];
	// Format data is popped and thrown away [R8]
	assign fifoOutRdy = (st_q == S_IDENT) ? popApb : drain;

	adf_fifo #(
		.W(FIFO_W),
		.D(FIFO_D)
	) u_fifo (
		.clk(core_clk),
		.rst(rst),
		.inVal(fifoInVal),
		.inRdy(fifoInRdy),
		.inData(fifoInData),
		.outVal(fifoOutVal),
		.outRdy(fifoOutRdy),
		.outData(fifoOutData)
	);

	// Host-written task file and control bits
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			feat_q <= 8'h00;
			scnt_q <= 8'h01;
			snum_q <= 8'h01;
			cylo_q <= 8'h00;
			cyhi_q <= 8'h00;
			dh_q <= 8'h00;
			ctrl_q <= CTRL_RST;
		end else if (go & pwrite) begin
			case (paddr)
				OFF_ERRFEAT: feat_q <= pwdata[7:0];
				OFF_SCNT: scnt_q <= pwdata[7:0];
				OFF_SNUM: snum_q <= pwdata[7:0];
				OFF_CYLO: cylo_q <= pwdata[7:0];
				OFF_CYHI: cyhi_q <= pwdata[7:0];
				OFF_DRVHEAD: dh_q <= pwdata[7:0];
				OFF_CTRL: ctrl_q <= pwdata[3:0];
				default: ;
			endcase
		end
	end

	// Answer after one wait cycle; unmapped offsets error
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= go;
			pslverr <= go & (paddr > OFF_CTRL | paddr[1:0] != 2'b00);
			prdata <= 32'h0000_0000;
			if (go & ~pwrite) begin
				case (paddr)
					OFF_DATA: prdata[15:0] <= popApb ? fifoOutData : 16'h0000;
					OFF_ERRFEAT: prdata[7:0] <= err_q;
					OFF_SCNT: prdata[7:0] <= scnt_q;
					OFF_SNUM: prdata[7:0] <= snum_q;
					OFF_CYLO: prdata[7:0] <= cylo_q;
					OFF_CYHI: prdata[7:0] <= cyhi_q;
					OFF_DRVHEAD: prdata[7:0] <= dh_q;
					OFF_STATCMD: prdata[7:0] <= {bsy_q, ~bsy_q, 1'b0,
						~bsy_q, drq_q, 2'b00, errSt_q};
					OFF_CTRL: prdata[3:0] <= ctrl_q;
					default: ;
				endcase
			end
		end
	end

	// Command sequencer
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st_q <= S_IDLE;
			bsy_q <= 1'b0;
			drq_q <= 1'b0;
			errSt_q <= 1'b0;
			err_q <= DIAG_OK;
			done_q <= 1'b0;
			flushReq <= 1'b0;
			fmtReq <= 1'b0;
			fmtLba <= 1'b0;
			fmtAddr <= 28'h000_0000;
			fmtCount <= 9'h000;
			genCnt_q <= 9'h000;
			xfer_q <= 9'h000;
		end else begin
			done_q <= 1'b0;
			case (st_q)
				S_IDLE: begin
					if (cmdWr & (selected | (ctrl_q[CT_TRUEIDE] &
						pwdata[7:0] == CMD_DIAG))) begin
						bsy_q <= 1'b1;
						drq_q <= 1'b0;
						errSt_q <= 1'b0;
						err_q <= 8'h00;
						genCnt_q <= 9'h000;
						xfer_q <= 9'h000;
						case (pwdata[7:0])
							CMD_DIAG: st_q <= S_DIAG; // [R1] [R2]
							CMD_FLUSH: begin
								if (ctrl_q[CT_FLUSHEN]) begin
									st_q <= S_FLUSH;
									flushReq <= 1'b1;
								end else begin
									err_q <= ERR_ABRT; // [R6]
									errSt_q <= 1'b1;
									bsy_q <= 1'b0;
									done_q <= 1'b1;
								end
							end
							CMD_FORMAT: begin
								st_q <= S_FMTBUF;
								fmtLba <= dh_q[DH_LBA];
								// Start address from LBA or CHS [R13]
								fmtAddr <= dh_q[DH_LBA] ?
									{dh_q[3:0], cyhi_q, cylo_q, 8'h00} :
									{cyhi_q, cylo_q, dh_q[3:0], 8'h00};
								// LBA zero count means 256; CHS uses TRACK_SECT [R9]
								fmtCount <= !dh_q[DH_LBA] ? TRACK_SECT :
									(scnt_q == 8'h00) ? SECT_WORDS :
									{1'b0, scnt_q};
							end
							CMD_IDENT: st_q <= S_IDENT;
							default: begin
								err_q <= ERR_ABRT;
								errSt_q <= 1'b1;
								bsy_q <= 1'b0;
								done_q <= 1'b1;
							end
						endcase
					end
				end
				S_DIAG: begin
					// Master folds in the slave's result [R3] [R4]
					err_q <= (ctrl_q[CT_TRUEIDE] & ~ctrl_q[CT_SLAVE] &
						slaveBad) ? (DIAG_SLAVE | DIAG_OK) : DIAG_OK;
					bsy_q <= 1'b0;
					done_q <= 1'b1;
					st_q <= S_IDLE;
				end
				S_FLUSH: begin
					// Hold busy until the media reports the cache empty [R5]
					if (flushDone) begin
						flushReq <= 1'b0;
						bsy_q <= 1'b0;
						done_q <= 1'b1;
						st_q <= S_IDLE;
					end
				end
				S_FMTBUF: begin
					if (!drq_q) begin
						drq_q <= 1'b1; // [R14]
						bsy_q <= 1'b0;
					end else if (fifoOutVal) begin
						xfer_q <= xfer_q + 9'h001;
						if (xfer_q == SECT_WORDS - 9'h001) begin
							drq_q <= 1'b0;
							bsy_q <= 1'b1;
							fmtReq <= 1'b1; // [R7]
							st_q <= S_FMTMED;
						end
					end
				end
				S_FMTMED: begin
					if (fmtDone) begin
						fmtReq <= 1'b0;
						bsy_q <= 1'b0;
						done_q <= 1'b1;
						st_q <= S_IDLE;
					end
				end
				S_IDENT: begin
					// Read-sector style: DRQ once data sits in the buffer [R11]
					if (genVal & fifoInRdy) begin
						genCnt_q <= genCnt_q + 9'h001;
					end
					if (!drq_q & fifoOutVal) begin
						drq_q <= 1'b1;
						bsy_q <= 1'b0;
					end
					if (popApb) begin
						xfer_q <= xfer_q + 9'h001;
						if (xfer_q == SECT_WORDS - 9'h001) begin
							drq_q <= 1'b0;
							done_q <= 1'b1;
							st_q <= S_IDLE;
						end
					end
				end
				default: st_q <= S_IDLE;
			endcase
		end
	end

	// Completion interrupt; a new event beats the clear [R15]
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			intrq <= 1'b0;
		end else if (done_q & ~ctrl_q[CT_INTDIS]) begin
			intrq <= 1'b1;
		end else if (cmdWr | (go & ~pwrite & paddr == OFF_STATCMD)) begin
			intrq <= 1'b0;
		end
	end

	// Helper: cycles spent waiting for DRQ in format
	logic [31:0] wait_q;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wait_q <= 32'h0000_0000;
		end else begin
			wait_q <= (st_q == S_FMTBUF & ~drq_q) ? wait_q + 32'h0000_0001 :
				32'h0000_0000;
		end
	end

	AST_DIAG_CARD: assert property (@(posedge core_clk) disable iff (rst) // [R1]
		st_q == S_IDLE & cmdWr & pwdata[7:0] == CMD_DIAG &
		~ctrl_q[CT_TRUEIDE] & ~selected |=> st_q == S_IDLE & ~bsy_q)
		else $error("diagnostic ran on unselected card");
	AST_DIAG_IDE: assert property (@(posedge core_clk) disable iff (rst) // [R2]
		st_q == S_IDLE & cmdWr & pwdata[7:0] == CMD_DIAG &
		ctrl_q[CT_TRUEIDE] |=> st_q == S_DIAG ##1 done_q)
		else $error("diagnostic not run in true IDE");
	AST_DIAG_MASTER: assert property (@(posedge core_clk) disable iff (rst) // [R3]
		st_q == S_DIAG & ctrl_q[CT_TRUEIDE] & ~ctrl_q[CT_SLAVE] & slaveBad
		|=> err_q == 8'h81)
		else $error("master lost slave diagnostic");
	AST_DIAG_CODE: assert property (@(posedge core_clk) disable iff (rst) // [R4]
		st_q == S_DIAG |=> err_q == 8'h01 || err_q == 8'h81)
		else $error("bad diagnostic code");
	AST_FLUSH_HOLD: assert property (@(posedge core_clk) disable iff (rst) // [R5]
		st_q == S_FLUSH & ~flushDone |=> bsy_q & flushReq)
		else $error("flush released before media done");
	AST_FLUSH_ABORT: assert property (@(posedge core_clk) disable iff (rst) // [R6]
		st_q == S_IDLE & cmdWr & selected & pwdata[7:0] == CMD_FLUSH &
		~ctrl_q[CT_FLUSHEN] |=> err_q == ERR_ABRT & errSt_q & ~bsy_q)
		else $error("unsupported flush not aborted");
	AST_FMT_DISCARD: assert property (@(posedge core_clk) disable iff (rst) // [R8]
		$rose(fmtReq) |-> ~fifoOutVal & xfer_q == SECT_WORDS)
		else $error("format buffer not fully taken");
	AST_FMT_COUNT: assert property (@(posedge core_clk) disable iff (rst) // [R9]
		$rose(fmtReq) & fmtLba |-> fmtCount ==
		(scnt_q == 8'h00 ? 9'h100 : {1'b0, scnt_q}))
		else $error("format count wrong");
	AST_FMT_ADDR: assert property (@(posedge core_clk) disable iff (rst) // [R13]
		$rose(fmtReq) |-> fmtAddr[19:8] == (fmtLba ?
		{cyhi_q[3:0], cylo_q} : {cylo_q, dh_q[3:0]}))
		else $error("format address wrong");
	AST_FMT_DRQ: assert property (@(posedge core_clk) disable iff (rst) // [R14]
		st_q == S_IDLE & cmdWr & selected & pwdata[7:0] == CMD_FORMAT
		|=> bsy_q ##1 drq_q & ~bsy_q)
		else $error("format DRQ sequence wrong");
	AST_DRQ_LIMIT: assert property (@(posedge core_clk) disable iff (rst) // [R14]
		wait_q < DrqMaxCyc && wait_q < BSY_CLR_CYC)
		else $error("DRQ late");
	AST_IDENT_ZERO: assert property (@(posedge core_clk) disable iff (rst) // [R12]
		popApb & xfer_q != 9'h000 |=> prdata == 32'h0000_0000)
		else $error("reserved identify word not zero");
	AST_DONE_IRQ: assert property (@(posedge core_clk) disable iff (rst) // [R15]
		done_q & ~ctrl_q[CT_INTDIS] |=> intrq & ~bsy_q)
		else $error("completion interrupt missing");
endmodule

/* adf_pkg.sv */
// Behaviour
// (R1) Card mode: diagnostic only on selected drive
// (R2) True IDE: diagnostic ignores drive select bit
// (R3) True IDE master reports both devices' result
// (R4) Diagnostic leaves a documented code in error
// (R5) Flush finishes media writes before RDY/DSC
// (R6) Flush unsupported: abort command
// (R7) Format fills head/cylinder with fill pattern
// (R8) Format takes one sector buffer, discards it
// (R9) LBA format count from sector count, 0=256
// (R10) Host should avoid format track command
// (R11) Identify returns block as single-sector read
// (R12) Reserved identify bits and words read zero
// (R13) Format address from CHS or LBA fields
// (R14) Write class: BSY, then DRQ, then BSY clear
// (R15) Completion clears BSY and interrupts host
package adf_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_DATA = 8'h00;
	localparam logic [7:0] OFF_ERRFEAT = 8'h04;
	localparam logic [7:0] OFF_SCNT = 8'h08;
	localparam logic [7:0] OFF_SNUM = 8'h0C;
	localparam logic [7:0] OFF_CYLO = 8'h10;
	localparam logic [7:0] OFF_CYHI = 8'h14;
	localparam logic [7:0] OFF_DRVHEAD = 8'h18;
	localparam logic [7:0] OFF_STATCMD = 8'h1C;
	localparam logic [7:0] OFF_CTRL = 8'h20;
	// Status bits
	localparam int ST_BSY = 7;
	localparam int ST_RDY = 6;
	localparam int ST_DSC = 4;
	localparam int ST_DRQ = 3;
	localparam int ST_ERR = 0;
	// Drive/head fields
	localparam int DH_LBA = 6;
	localparam int DH_DRV = 4;
	// Control register bits
	localparam int CT_TRUEIDE = 0;
	localparam int CT_SLAVE = 1;
	localparam int CT_FLUSHEN = 2;
	localparam int CT_INTDIS = 3;
	localparam logic [3:0] CTRL_RST = 4'h4;
	// Command codes
	localparam logic [7:0] CMD_DIAG = 8'h90;
	localparam logic [7:0] CMD_FLUSH = 8'hE7;
	localparam logic [7:0] CMD_FORMAT = 8'h50;
	localparam logic [7:0] CMD_IDENT = 8'hEC;
	// Error register values
	localparam logic [7:0] ERR_ABRT = 8'h04;
	localparam logic [7:0] DIAG_OK = 8'h01;
	localparam logic [7:0] DIAG_SLAVE = 8'h80;
	// Sector geometry and buffering
	localparam logic [8:0] SECT_WORDS = 9'h100;
	localparam logic [8:0] TRACK_SECT = 9'h020;
	localparam int FIFO_W = 16;
	localparam int FIFO_D = 32;
	// Identify word 0, arbitrary value
	localparam logic [15:0] IDENT_W0 = 16'h0040;
	// Timing
	localparam int CLK_MHZ = 125;
	localparam int DRQ_MAX_US = 700;
	localparam int BSY_CLR_NS = 400;
	localparam int BSY_CLR_CYC = BSY_CLR_NS * CLK_MHZ / 1000;
endpackage

/* adf_media_model.sv */
`timescale 1ns/100ps
// Stands in for the media engine behind the task file: it finishes a
// cache flush or a format only after a programmable latency, so both
// prompt and slow media can be tried from the bench.
module adf_media_model (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [7:0] lat,
	input wire logic flushReq,
	input wire logic fmtReq,
	output logic flushDone,
	output logic fmtDone
);
	logic [7:0] cntQ;

	// Count busy cycles; done is one pulse, then the count restarts
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cntQ <= 8'h00;
			flushDone <= 1'b0;
			fmtDone <= 1'b0;
		end else if ((flushReq || fmtReq) && cntQ < lat) begin
			cntQ <= cntQ + 8'h01;
			flushDone <= 1'b0;
			fmtDone <= 1'b0;
		end else begin
			// Done only after the whole latency, never while idle
			cntQ <= 8'h00;
			flushDone <= flushReq && !flushDone;
			fmtDone <= fmtReq && !fmtDone;
		end
	end
endmodule

/* ata_diag_flush_format_identify_test.sv */
`timescale 1ns/100ps
module ata_diag_flush_format_identify_test;
	import adf_pkg::*;
	logic core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
	logic slaveDiagOkN = 0, pready, pslverr, intrq, se, lb;
	logic flushReq, flushDone, fmtReq, fmtDone, fmtLba;
	logic [7:0] paddr = 0, lat = 8'h02, cl, ch, hd, sc;
	logic [31:0] pwdata = 0, prdata, rd;
	logic [27:0] fmtAddr;
	logic [8:0] fmtCount;
	logic [15:0] q[$];
	int error_cnt = 0, compares = 0, n;

	adf_ctrl #(.DrqMaxCyc(100)) adf_ctrl_i (.core_clk(core_clk),
		.rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .intrq(intrq),
		.slaveDiagOkN(slaveDiagOkN), .flushReq(flushReq),
		.flushDone(flushDone), .fmtReq(fmtReq), .fmtDone(fmtDone),
		.fmtLba(fmtLba), .fmtAddr(fmtAddr), .fmtCount(fmtCount));
	adf_media_model adf_media_model_i (.core_clk(core_clk), .rst(rst),
		.lat(lat), .flushReq(flushReq), .fmtReq(fmtReq),
		.flushDone(flushDone), .fmtDone(fmtDone));

	// 125 MHz clock
	initial begin
		forever #4 core_clk = ~core_clk;
	end

	task chk(input logic [31:0] g, input logic [31:0] e, input string m);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
		end
	endtask

	task test_done;
		$display("compares %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// One APB transfer; pready is read before the edge's updates land
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge core_clk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			k++;
		end while (pready !== 1'b1 && k < 4000);
		if (pready !== 1'b1) begin
			error_cnt++;
			$display("mismatch at %0t: apb transfer timed out", $time);
		end
		rd = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task rdc(input logic [7:0] a, input logic [31:0] e, input string m);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, e, m);
	endtask

	// Bounded wait for the completion interrupt, or its absence
	task irq(input logic e);
		n = 0;
		while (intrq !== 1'b1 && n < (e ? 3000 : 40)) begin
			@(posedge core_clk);
			n++;
		end
		chk(intrq, e, "intrq");
	endtask

	// Status polling also clears intrq, so only used before data moves
	task drq;
		n = 0;
		do apb(1'b0, OFF_STATCMD, 32'h0000_0000);
		while (rd[ST_DRQ] !== 1'b1 && n++ < 200);
		chk(rd & 32'h0000_0089, 32'h0000_0008, "drq, bsy clear");
	endtask

	initial begin
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
		n = $urandom(32'h750bbc42);
		rdc(OFF_SCNT, 32'h0000_0001, "scnt");
		rdc(OFF_SNUM, 32'h0000_0001, "snum");
		rdc(OFF_ERRFEAT, DIAG_OK, "err");
		rdc(OFF_CTRL, CTRL_RST, "ctrl");
		rdc(OFF_STATCMD, 32'h0000_0050, "status");
		apb(1'b0, 8'h24, 32'h0000_0000);
		chk(se, 1'b1, "unmapped slverr");
		$display("test reset done");
		// Flush on a device without flush support
		wr(OFF_CTRL, 32'h0000_0000);
		wr(OFF_DRVHEAD, 32'h0000_0000);
		wr(OFF_STATCMD, CMD_FLUSH);
		irq(1'b1);
		rdc(OFF_STATCMD, 32'h0000_0051, "abort status");
		rdc(OFF_ERRFEAT, ERR_ABRT, "abort code");
		// Card mode: the other drive is addressed, so nothing runs
		wr(OFF_CTRL, 32'h0000_0004);
		wr(OFF_DRVHEAD, 32'h0000_0010);
		wr(OFF_STATCMD, CMD_DIAG);
		irq(1'b0);
		rdc(OFF_ERRFEAT, ERR_ABRT, "unselected diag");
		wr(OFF_DRVHEAD, 32'h0000_0000);
		wr(OFF_STATCMD, CMD_DIAG);
		irq(1'b1);
		rdc(OFF_ERRFEAT, DIAG_OK, "diag ok");
		// True IDE master: drive bit ignored, slave result merged in
		for (int i = 0; i < 2; i++) begin
			slaveDiagOkN <= i[0];
			wr(OFF_CTRL, 32'h0000_0005);
			wr(OFF_DRVHEAD, 32'h0000_0010);
			wr(OFF_STATCMD, CMD_DIAG);
			irq(1'b1);
			rdc(OFF_ERRFEAT, i ? DIAG_SLAVE | DIAG_OK : DIAG_OK, "ide");
		end
		// Interrupt disabled: completion stays silent
		wr(OFF_CTRL, 32'h0000_000C);
		wr(OFF_DRVHEAD, 32'h0000_0000);
		wr(OFF_STATCMD, CMD_DIAG);
		irq(1'b0);
		$display("test diagnostic done");
		// Slow media: ready only once the cache reached the media
		lat <= 8'h28;
		wr(OFF_CTRL, 32'h0000_0004);
		wr(OFF_STATCMD, CMD_FLUSH);
		rdc(OFF_STATCMD, 32'h0000_0080, "flush busy");
		chk(flushReq, 1'b1, "flush req");
		irq(1'b1);
		rdc(OFF_STATCMD, 32'h0000_0050, "flush rdy dsc");
		chk(flushReq, 1'b0, "flush req low");
		$display("test flush done");
		// CHS, LBA count 0, LBA random count; few runs only
		lat <= 8'h03;
		for (int i = 0; i < 3; i++) begin
			lb = i != 0;
			sc = (i == 2) ? 8'($urandom_range(255, 1)) : 8'h00;
			cl = $urandom;
			ch = $urandom;
			hd = $urandom & 32'h0000_000F;
			wr(OFF_CYLO, {24'h0, cl});
			wr(OFF_CYHI, {24'h0, ch});
			wr(OFF_SCNT, lb ? {24'h0, sc} : 32'h0000_0005);
			wr(OFF_DRVHEAD, {25'h0, lb, 2'b00, hd[3:0]});
			wr(OFF_STATCMD, CMD_FORMAT);
			drq();
			for (int k = 0; k < 256; k++) wr(OFF_DATA, $urandom);
			n = 0;
			while (fmtReq !== 1'b1 && n < 500) begin
				@(posedge core_clk);
				n++;
			end
			chk(fmtReq, 1'b1, "fmt req");
			chk(fmtLba, lb, "fmt lba");
			chk(fmtAddr, lb ? {hd[3:0], ch, cl, 8'h0} : {ch, cl, hd[3:0], 8'h0},
				"fmt addr");
			chk(fmtCount, !lb ? TRACK_SECT : (sc == 8'h00) ? 9'h100 :
				{1'b0, sc}, "fmt count");
			irq(1'b1);
			rdc(OFF_STATCMD, 32'h0000_0050, "fmt end");
		end
		$display("test format done");
		// Identify: one sector read, all reserved words zero
		q.push_back(IDENT_W0);
		repeat (255) q.push_back(16'h0000);
		wr(OFF_STATCMD, CMD_IDENT);
		drq();
		for (int k = 0; k < 256; k++) begin
			apb(1'b0, OFF_DATA, 32'h0000_0000);
			chk(rd, {16'h0, q.pop_front()}, "ident word");
		end
		rdc(OFF_STATCMD, 32'h0000_0050, "ident end");
		$display("test identify done");
		test_done();
	end

	// Whole run is near 40 us; a hang ends here
	initial begin
		#400_000;
		error_cnt++;
		$display("mismatch at %0t: watchdog expired", $time);
		test_done();
	end
endmodule
